// ---- design/bsl_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module bsl_fifo
	import bsl_pkg::*;
#(
	parameter int WIDTH = 48,
	parameter int DEPTH = 4
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	// ==========================================================
	// handshakes: full and empty come straight from the count
	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rp_q];

	// storage has no reset; only pointers and count need a defined state
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	// pointers wrap naturally since depth is a power of two
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= rp_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	fifo_bound_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // R21
		cnt_q <= DEPTH[AW:0])
		else $error("fifo count beyond depth");
endmodule
`default_nettype wire

// ---- design/bsl_loader.sv ----
// Operation
// R1: header word one carries tag in bits 15:0, upper bits ignored.
// R2: header word two holds start address in 47:16, count in 15:0.
// R3: body words follow header, one per counted word, ascending.
// R4: producer omits body of all-zero blocks, sending zero-fill tag.
// R5: zero-fill writes zeros over count locations, consuming no stream words.
// R6: init block stores each body word at successive addresses.
// R7: sixteen-bit tag precedes every block, each type distinct.
// R8: data zero-fill tags 0001, 0002, 0003 and 000F.
// R9: data init tags 0004, 0005 and 0010.
// R10: program zero-fill tags 0007, 0008, 0009, 000A and 0011.
// R11: program init tags 000B, 000C, 000E and 0012.
// R12: tag zero marks the final block, always last.
// R13: word after final tag becomes program transfer instruction.
// R14: final init starts overwrite transfer and restores default config.
// R15: boot port enabled before reading each header.
// R16: setup of address, interrupt, id and wait state precedes loading.
// R17: producer places return-from-interrupt at boot port vector.
// R18: execution resumes at second reset vector location.
// R19: producer warns when reset vector holds other than nop or idle.
// R20: host boot automatic transfer stops after 256 kernel instructions.
// R21: external port halves packed into 48-bit words before parsing.
// R22: unknown tag halts processing and raises error flag.
// R23: blocks parsed strictly in sequence until the final tag.
`timescale 1ns/1ps
`default_nettype none
module bsl_loader
	import bsl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic link_boot,
	input wire logic ext_valid,
	input wire logic [TAG_W-1:0] ext_half,
	input wire logic link_valid,
	input wire logic [WORD_W-1:0] link_word,
	output logic port_ready,
	output logic ext_port_en,
	output logic link_port_en,
	output logic setup_done,
	output logic kernel_done,
	output logic mem_we,
	output bsl_mem_wr_t mem_wr,
	output logic [WORD_W-1:0] program_transfer_reg,
	output bsl_cfg_t cfg,
	output logic [ADDR_W-1:0] resume_pc,
	output logic overwrite_start,
	output logic boot_done,
	output logic stream_err
);
	typedef enum logic [2:0] {
		BSL_S_SETUP = 3'b000,
		BSL_S_KERNEL = 3'b001,
		BSL_S_HDR0 = 3'b010,
		BSL_S_HDR1 = 3'b011,
		BSL_S_BODY = 3'b100,
		BSL_S_ZERO = 3'b101,
		BSL_S_XFER = 3'b110,
		BSL_S_DONE = 3'b111
	} bsl_state_t;

	// ==========================================================
	// tag decode, used for both kind and memory space
	function automatic bsl_kind_t tag_kind(input logic [15:0] t);
		case (t) // R7
			TAG_FINAL: tag_kind = BSL_K_FINAL; // R12
			TAG_ZDM16, TAG_ZDM32, TAG_ZDM40, TAG_ZDM64: // R8
				tag_kind = BSL_K_ZERO;
			TAG_IDM16, TAG_IDM32, TAG_IDM64: // R9
				tag_kind = BSL_K_INIT;
			TAG_ZPM16, TAG_ZPM32, TAG_ZPM40, TAG_ZPM48, TAG_ZPM64: // R10
				tag_kind = BSL_K_ZERO;
			TAG_IPM16, TAG_IPM32, TAG_IPM48, TAG_IPM64: // R11
				tag_kind = BSL_K_INIT;
			default: tag_kind = BSL_K_BAD; // R22
		endcase
	endfunction

	function automatic logic tag_is_pm(input logic [15:0] t);
		tag_is_pm = (t >= TAG_ZPM16 && t <= TAG_IPM48 && t != TAG_ZDM64) ||
			t == TAG_ZPM64 || t == TAG_IPM64;
	endfunction

	bsl_state_t state_q;
	logic [15:0] tag_q;
	logic [ADDR_W-1:0] addr_q;
	logic [CNT_W-1:0] cnt_q;
	logic [1:0] half_q;
	logic [31:0] pack_q;
	logic pack_valid_q;
	logic [WORD_W-1:0] pack_word_q;
	logic [8:0] kcnt_q;
	logic src_valid;
	logic [WORD_W-1:0] src_word;
	logic src_ready;
	logic src_push;
	logic f_valid;
	logic f_ready;
	logic [WORD_W-1:0] f_word;
	logic want;
	logic take;
	bsl_kind_t kind;

	// ==========================================================
	// external packing: three 16-bit halves, low half first
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			half_q <= 2'h0;
			pack_q <= 32'h0000_0000;
			pack_valid_q <= 1'b0;
			pack_word_q <= 48'h0;
		end else begin
			if (pack_valid_q && src_ready) begin
				pack_valid_q <= 1'b0;
			end
			if (ext_valid && port_ready && !link_boot) begin // R21
				if (half_q == 2'(PACK_HALVES - 1)) begin
					pack_word_q <= {ext_half, pack_q};
					pack_valid_q <= 1'b1;
					half_q <= 2'h0;
				end else begin
					pack_q <= {ext_half, pack_q[31:16]};
					half_q <= half_q + 2'h1;
				end
			end
		end
	end

	// link words arrive whole and count only while port_ready is up,
	// exactly as the source sees it; ready stalls the packer too
	assign src_valid = link_boot ? (link_valid && port_ready) : pack_valid_q;
	assign src_push = src_valid && src_ready;
	assign src_word = link_boot ? link_word : pack_word_q;

	bsl_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.in_valid(src_valid),
		.in_ready(src_ready),
		.in_data(src_word),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_word)
	);

	// ==========================================================
	// consumer side: words are drawn only in states that parse them
	assign want = (state_q == BSL_S_KERNEL) || (state_q == BSL_S_HDR0) ||
		(state_q == BSL_S_HDR1) || (state_q == BSL_S_BODY) ||
		(state_q == BSL_S_XFER);
	assign f_ready = want;
	assign take = want && f_valid;
	assign kind = tag_kind(tag_q);

	// port ready registered; it drops for a cycle after every push so
	// that a word offered under it always finds room despite the lag
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			port_ready <= 1'b0;
			ext_port_en <= 1'b0;
			link_port_en <= 1'b0;
		end else begin
			port_ready <= src_ready && !src_push && !pack_valid_q &&
				state_q != BSL_S_DONE && state_q != BSL_S_SETUP;
			ext_port_en <= !link_boot && state_q != BSL_S_SETUP && // R15
				state_q != BSL_S_DONE;
			link_port_en <= link_boot && state_q != BSL_S_SETUP && // R15
				state_q != BSL_S_DONE;
		end
	end

	// ==========================================================
	// block sequencer
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= BSL_S_SETUP;
			tag_q <= 16'h0000;
			addr_q <= 32'h0000_0000;
			cnt_q <= 16'h0000;
			kcnt_q <= 9'h000;
			setup_done <= 1'b0;
			kernel_done <= 1'b0;
			stream_err <= 1'b0;
		end else begin
			case (state_q)
				BSL_S_SETUP: begin
					setup_done <= 1'b1; // R16
					state_q <= link_boot ? BSL_S_HDR0 : BSL_S_KERNEL;
				end
				BSL_S_KERNEL: if (take) begin
					// host boot: first kernel words pass through untouched
					kcnt_q <= kcnt_q + 9'h001;
					if (kcnt_q == 9'(KERNEL_WORDS - 1)) begin // R20
						kernel_done <= 1'b1;
						state_q <= BSL_S_HDR0;
					end
				end
				BSL_S_HDR0: if (take) begin
					tag_q <= f_word[TAG_W-1:0]; // R1
					state_q <= BSL_S_HDR1;
				end
				BSL_S_HDR1: if (take) begin
					addr_q <= f_word[WORD_W-1:ADDR_LSB]; // R2
					cnt_q <= f_word[CNT_W-1:0]; // R2
					case (kind)
						BSL_K_FINAL: state_q <= BSL_S_XFER; // R13
						BSL_K_ZERO: state_q <= (f_word[15:0] == 16'h0000) ?
							BSL_S_HDR0 : BSL_S_ZERO; // R5
						BSL_K_INIT: state_q <= (f_word[15:0] == 16'h0000) ?
							BSL_S_HDR0 : BSL_S_BODY; // R6
						default: begin
							stream_err <= 1'b1; // R22
							state_q <= BSL_S_DONE;
						end
					endcase
				end
				BSL_S_BODY: if (take) begin
					addr_q <= addr_q + 32'h1; // R3
					cnt_q <= cnt_q - 16'h1;
					if (cnt_q == 16'h0001) begin
						state_q <= BSL_S_HDR0; // R23
					end
				end
				BSL_S_ZERO: begin
					// no stream words drawn here
					addr_q <= addr_q + 32'h1; // R5
					cnt_q <= cnt_q - 16'h1;
					if (cnt_q == 16'h0001) begin
						state_q <= BSL_S_HDR0; // R23
					end
				end
				BSL_S_XFER: if (take) begin
					state_q <= BSL_S_DONE;
				end
				BSL_S_DONE: state_q <= BSL_S_DONE;
				default: state_q <= BSL_S_SETUP;
			endcase
		end
	end

	// ==========================================================
	// memory write port
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_we <= 1'b0;
			mem_wr <= '0;
		end else begin
			mem_we <= (state_q == BSL_S_ZERO) || (state_q == BSL_S_BODY && take);
			mem_wr.pm <= tag_is_pm(tag_q);
			mem_wr.addr <= addr_q;
			mem_wr.data <= (state_q == BSL_S_BODY) ? f_word : 48'h0; // R5 R6
		end
	end

	// ==========================================================
	// final initialization: transfer reg, overwrite, defaults
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			program_transfer_reg <= 48'h0;
			overwrite_start <= 1'b0;
			boot_done <= 1'b0;
			resume_pc <= 32'h0000_0000;
			cfg.system_config_reg <= SYSCFG_DEF;
			cfg.dma_channel_control <= DMACTL_BOOT;
			cfg.link_port_control <= LINKCTL_DEF;
		end else begin
			overwrite_start <= 1'b0;
			if (state_q == BSL_S_XFER && take) begin
				program_transfer_reg <= f_word; // R13
				overwrite_start <= 1'b1; // R14
				boot_done <= 1'b1;
				resume_pc <= RESUME_ADDR; // R18
				cfg.system_config_reg <= SYSCFG_DEF; // R14
				cfg.dma_channel_control <= DMACTL_DEF; // R14
				cfg.link_port_control <= LINKCTL_DEF; // R14
			end
		end
	end

	// ==========================================================
	// checks
	zero_no_take_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		state_q == BSL_S_ZERO |-> !f_ready) // R5
		else $error("zero fill consumed a stream word");
	zero_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		state_q == BSL_S_ZERO |=> mem_we && mem_wr.data == 48'h0) // R5
		else $error("zero fill did not write zero");
	zero_count_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // R5
		state_q == BSL_S_ZERO && cnt_q != 16'h0001 |=>
		state_q == BSL_S_ZERO && cnt_q == $past(cnt_q) - 16'h1)
		else $error("zero fill count not stepping");
	body_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		state_q == BSL_S_BODY && take |=> mem_we &&
		mem_wr.data == $past(f_word) && mem_wr.addr == $past(addr_q)) // R6
		else $error("body word not stored");
	addr_step_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		state_q == BSL_S_BODY && take && cnt_q != 16'h0001 |=>
		addr_q == $past(addr_q) + 32'h1) // R3
		else $error("body address not ascending");
	bad_tag_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		state_q == BSL_S_HDR1 && take && kind == BSL_K_BAD |=>
		stream_err && state_q == BSL_S_DONE) // R22
		else $error("bad tag not flagged");
	final_xfer_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		state_q == BSL_S_XFER && take |=> program_transfer_reg == $past(f_word)
		&& overwrite_start && cfg.dma_channel_control == DMACTL_DEF) // R13
		else $error("final word not loaded");
	port_before_hdr_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		state_q == BSL_S_HDR0 && take |-> ext_port_en || link_port_en) // R15
		else $error("header read with port off");
	setup_first_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		mem_we |-> setup_done) // R16
		else $error("memory loaded before setup");
	kernel_stop_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		state_q == BSL_S_KERNEL && take && kcnt_q == 9'(KERNEL_WORDS - 1) |=>
		state_q == BSL_S_HDR0 && kernel_done) // R20
		else $error("kernel transfer did not stop");
	tag_low_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		state_q == BSL_S_HDR0 && take |=> tag_q == 16'($past(f_word))) // R1
		else $error("tag not from low bits");
	resume_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		boot_done |-> resume_pc == RESUME_ADDR) // R18
		else $error("resume address wrong");
endmodule
`default_nettype wire

// ---- design/bsl_pkg.sv ----
package bsl_pkg;
	// ==========================================================
	// stream word layout
	localparam int WORD_W = 48;
	localparam int TAG_W = 16;
	localparam int CNT_W = 16;
	localparam int ADDR_W = 32;
	localparam int ADDR_LSB = 16;
	localparam int FIFO_DEPTH = 4;
	localparam int KERNEL_WORDS = 256;
	localparam int PACK_HALVES = 3;

	// ==========================================================
	// block tags
	localparam logic [15:0] TAG_FINAL = 16'h0000;
	localparam logic [15:0] TAG_ZDM16 = 16'h0001;
	localparam logic [15:0] TAG_ZDM32 = 16'h0002;
	localparam logic [15:0] TAG_ZDM40 = 16'h0003;
	localparam logic [15:0] TAG_IDM16 = 16'h0004;
	localparam logic [15:0] TAG_IDM32 = 16'h0005;
	localparam logic [15:0] TAG_ZPM16 = 16'h0007;
	localparam logic [15:0] TAG_ZPM32 = 16'h0008;
	localparam logic [15:0] TAG_ZPM40 = 16'h0009;
	localparam logic [15:0] TAG_ZPM48 = 16'h000A;
	localparam logic [15:0] TAG_IPM16 = 16'h000B;
	localparam logic [15:0] TAG_IPM32 = 16'h000C;
	localparam logic [15:0] TAG_IPM48 = 16'h000E;
	localparam logic [15:0] TAG_ZDM64 = 16'h000F;
	localparam logic [15:0] TAG_IDM64 = 16'h0010;
	localparam logic [15:0] TAG_ZPM64 = 16'h0011;
	localparam logic [15:0] TAG_IPM64 = 16'h0012;

	// ==========================================================
	// default values restored at final init, plus the reset-time DMA control and the resume address
	localparam logic [31:0] SYSCFG_DEF = 32'h0000_0000;
	localparam logic [31:0] DMACTL_DEF = 32'h0000_0000;
	localparam logic [31:0] LINKCTL_DEF = 32'h0000_0000;
	localparam logic [31:0] DMACTL_BOOT = 32'h0000_00A1;
	localparam logic [31:0] RESUME_ADDR = 32'h0004_0005;

	// ==========================================================
	// kinds of block
	typedef enum logic [1:0] {
		BSL_K_ZERO = 2'b00,
		BSL_K_INIT = 2'b01,
		BSL_K_FINAL = 2'b10,
		BSL_K_BAD = 2'b11
	} bsl_kind_t;

	typedef struct packed {
		logic pm;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] data;
	} bsl_mem_wr_t;

	typedef struct packed {
		logic [31:0] system_config_reg;
		logic [31:0] dma_channel_control;
		logic [31:0] link_port_control;
	} bsl_cfg_t;
endpackage

// ---- verification/bsl_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module bsl_src_model
	import bsl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic link_boot,
	input wire logic slow,
	input wire logic port_ready,
	output logic ext_valid,
	output logic [TAG_W-1:0] ext_half,
	output logic link_valid,
	output logic [WORD_W-1:0] link_word
);
	// ==========================================================
	// word queue filled by the bench
	logic [WORD_W-1:0] q[$];
	logic [WORD_W-1:0] head;
	int half_q;
	logic gap_q;

	task push(input logic [WORD_W-1:0] w);
		q.push_back(w);
	endtask

	task flush();
		q.delete();
	endtask

	// ==========================================================
	// offer, hold until taken, then release
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ext_valid <= 1'b0;
			link_valid <= 1'b0;
			ext_half <= 16'h0000;
			link_word <= 48'h0;
			half_q <= 0;
			gap_q <= 1'b0;
		end else if ((ext_valid || link_valid) && port_ready) begin
			ext_valid <= 1'b0;
			link_valid <= 1'b0;
			gap_q <= slow; // slow source leaves a gap
			ext_half <= ~ext_half;
			link_word <= ~link_word;
			if (link_boot || half_q == 2) begin
				void'(q.pop_front());
				half_q <= 0;
			end else begin
				half_q <= half_q + 1;
			end
		end else if (!ext_valid && !link_valid) begin
			gap_q <= 1'b0;
			if (!gap_q && port_ready && q.size() > 0) begin
				head = q[0];
				if (link_boot) begin
					link_valid <= 1'b1;
					link_word <= head;
				end else begin
					ext_valid <= 1'b1;
					ext_half <= head[16*half_q +: 16];
				end
			end else begin
				// released lines never repeat the last value
				ext_half <= ~ext_half;
				link_word <= ~link_word;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb
	import bsl_pkg::*;
;
	logic sys_clk, arst_n, link_boot, slow;
	logic ext_valid, link_valid, port_ready, ext_port_en, link_port_en;
	logic [TAG_W-1:0] ext_half;
	logic [WORD_W-1:0] link_word, program_transfer_reg;
	logic setup_done, kernel_done, mem_we, overwrite_start;
	logic boot_done, stream_err;
	bsl_mem_wr_t mem_wr;
	bsl_cfg_t cfg;
	logic [ADDR_W-1:0] resume_pc;
	int failures, n_checks, n_ovw;
	bsl_mem_wr_t exp_q[$];
	logic [15:0] tags[16] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004,
		16'h0005, 16'h0007, 16'h0008, 16'h0009, 16'h000A, 16'h000B,
		16'h000C, 16'h000E, 16'h000F, 16'h0010, 16'h0011, 16'h0012};
	// arbitrary stand-in encoding and vector slot for the producer's word
	localparam logic [WORD_W-1:0] RET_INSTR = 48'h0000_0000_0A0B;
	localparam logic [31:0] BOOT_VEC_ADDR = 32'h0004_0050;

	bsl_loader i_bsl_loader(.sys_clk, .arst_n, .link_boot, .ext_valid,
		.ext_half, .link_valid, .link_word, .port_ready, .ext_port_en,
		.link_port_en, .setup_done, .kernel_done, .mem_we, .mem_wr,
		.program_transfer_reg, .cfg, .resume_pc, .overwrite_start,
		.boot_done, .stream_err);
	bsl_src_model i_bsl_src_model(.sys_clk, .arst_n, .link_boot, .slow,
		.port_ready, .ext_valid, .ext_half, .link_valid, .link_word);

	// ==========================================================
	// clock and compare helpers
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task check(input logic [127:0] seen, input logic [127:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task tally_and_finish();
		if (failures == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// every memory write must be the next one expected
	always @(posedge sys_clk) begin
		if (arst_n === 1'b1 && mem_we === 1'b1) begin
			if (exp_q.size() == 0) check(mem_wr, '1);
			else check(mem_wr, exp_q.pop_front());
		end
		if (arst_n === 1'b1 && overwrite_start === 1'b1) n_ovw++;
	end

	// ==========================================================
	// stream building
	task add_blk(input logic [15:0] tag, input logic [31:0] addr,
		input int cnt);
		logic pm;
		logic init;
		bsl_mem_wr_t w;
		pm = tag inside {16'h0007, 16'h0008, 16'h0009, 16'h000A, 16'h000B,
			16'h000C, 16'h000E, 16'h0011, 16'h0012};
		init = tag inside {16'h0004, 16'h0005, 16'h000B, 16'h000C,
			16'h000E, 16'h0010, 16'h0012};
		// junk above the tag must not matter
		i_bsl_src_model.push({32'hA5C3_0F96, tag});
		i_bsl_src_model.push({addr, cnt[15:0]});
		for (int i = 0; i < cnt; i++) begin
			w.pm = pm;
			w.addr = addr + 32'(i);
			w.data = {16'h5A5A, w.addr};
			if (init) i_bsl_src_model.push(w.data);
			else w.data = 48'h0;
			exp_q.push_back(w);
		end
	endtask

	task add_final(input logic [WORD_W-1:0] instr);
		i_bsl_src_model.push({32'h1357_9BDF, TAG_FINAL});
		i_bsl_src_model.push(48'h0);
		i_bsl_src_model.push(instr);
	endtask

	task do_reset(input logic lb, input logic sl);
		arst_n <= 1'b0;
		link_boot <= lb;
		slow <= sl;
		i_bsl_src_model.flush();
		exp_q.delete();
		n_ovw = 0;
		repeat (4) @(posedge sys_clk);
		check(cfg, {32'h0, DMACTL_BOOT, 32'h0});
		arst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		check(setup_done, 1'b1);
		check({ext_port_en, link_port_en}, {~lb, lb});
		check(kernel_done, 1'b0);
	endtask

	// bounded wait for the end of the stream
	task wait_end();
		int n;
		n = 0;
		while (boot_done !== 1'b1 && stream_err !== 1'b1 && n < 20000) begin
			@(posedge sys_clk);
			n++;
		end
		repeat (6) @(posedge sys_clk);
		check(n < 20000, 1'b1);
		check(exp_q.size(), 0);
	endtask

	task check_final(input logic [WORD_W-1:0] instr);
		check(boot_done, 1'b1);
		check(stream_err, 1'b0);
		check(program_transfer_reg, instr);
		check(cfg, {SYSCFG_DEF, DMACTL_DEF, LINKCTL_DEF});
		check(n_ovw, 1);
		check(resume_pc, RESUME_ADDR);
	endtask

	// ==========================================================
	// scenarios
	task t_all_tags();
		do_reset(1'b1, 1'b0);
		add_blk(TAG_IDM16, 32'h0000_0800, 0);
		for (int k = 0; k < 16; k++) begin
			add_blk(tags[k], 32'h0000_1000 + 32'(16 * k), k % 3 + 1);
		end
		add_final(48'hC0DE_1234_5678);
		wait_end();
		check_final(48'hC0DE_1234_5678);
		check(kernel_done, 1'b0);
	endtask

	task t_bad_tag(input logic [15:0] bad);
		do_reset(1'b1, 1'b1);
		add_blk(TAG_ZDM16, 32'h0000_2000, 2);
		i_bsl_src_model.push({32'h0, bad});
		i_bsl_src_model.push({32'h0000_3000, 16'h0001});
		i_bsl_src_model.push(48'h1111_2222_3333);
		i_bsl_src_model.push({32'h0, TAG_ZPM16});
		i_bsl_src_model.push({32'h0000_3100, 16'h0002});
		wait_end();
		check(stream_err, 1'b1);
		check(boot_done, 1'b0);
	endtask

	task t_host();
		do_reset(1'b0, 1'b1);
		for (int i = 0; i < KERNEL_WORDS; i++) begin
			i_bsl_src_model.push({16'hBEEF, 32'(i)});
		end
		add_blk(TAG_IPM48, 32'h0004_0100, 3);
		add_blk(TAG_ZDM64, 32'h0000_4000, 2);
		// return-from-interrupt word at the boot port vector
		i_bsl_src_model.push({32'h0, TAG_IPM48});
		i_bsl_src_model.push({BOOT_VEC_ADDR, 16'h0001});
		i_bsl_src_model.push(RET_INSTR);
		exp_q.push_back('{pm: 1'b1, addr: BOOT_VEC_ADDR, data: RET_INSTR});
		add_final(48'h8765_4321_0FED);
		wait_end();
		check(kernel_done, 1'b1);
		check_final(48'h8765_4321_0FED);
	endtask

	// ==========================================================
	// main sequence and watchdog
	initial begin
		arst_n = 1'b0;
		link_boot = 1'b1;
		slow = 1'b0;
		failures = 0;
		n_checks = 0;
		t_all_tags();
		t_bad_tag(16'h0006);
		t_bad_tag(16'h000D);
		t_host();
		tally_and_finish();
	end

	initial begin
		repeat (80000) @(posedge sys_clk);
		failures++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
